// ===== verilog/nvsc_pkg.sv
// package of constants and carriers for the nv save/restore control block
package nvsc_pkg;
    // ************************************************************
    // control-register target map
    // ************************************************************
    localparam logic [7:0] MEM_CTRL_OFS = 8'h00;
    localparam logic [7:0] SERIAL_FIRST_OFS = 8'h01;
    localparam logic [7:0] SERIAL_LAST_OFS = 8'h08;
    localparam logic [7:0] NV_COMMAND_ENTRY_OFS = 8'haa;
    localparam int PROTECT_LSB = 2;
    localparam int LOCK_BIT = 6;
    localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
    // ************************************************************
    // i2c target addresses (upper nibble)
    // ************************************************************
    localparam logic [3:0] MEM_TARGET_NIB = 4'ha;
    localparam logic [3:0] REG_TARGET_NIB = 4'h3;
    // ************************************************************
    // command bytes
    // ************************************************************
    localparam logic [7:0] CMD_SAVE = 8'h3c;
    localparam logic [7:0] CMD_RESTORE = 8'h60;
    localparam logic [7:0] AUTOSAVE_ON_CMD = 8'h59;
    localparam logic [7:0] AUTOSAVE_OFF_CMD = 8'h19;
    localparam logic [7:0] CMD_SLEEP = 8'hb9;
    // ************************************************************
    // protect ranges (top 17-bit address)
    // ************************************************************
    localparam logic [16:0] QUARTER_BASE = 17'h18000;
    localparam logic [16:0] HALF_BASE = 17'h10000;
    // ************************************************************
    // timing counts in clock cycles
    // ************************************************************
    localparam int SAVE_CYC = 800;
    localparam int RESTORE_CYC = 200;
    localparam int SETTLE_CYC = 100;
    localparam int DOZE_IN_CYC = 100;
    localparam int DOZE_OUT_CYC = 100;
    localparam int REQ_DLY_CYC = 10;
    localparam int HIGH_DRV_CYC = 10;
    localparam int HOLD_CYC = 10;
    // ************************************************************
    // carriers
    // ************************************************************
    // one received byte on the control-register target
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] data;
    } nvsc_wr_t;
    // nonvolatile image of the volatile settings
    typedef struct packed {
        logic autosave_en;
        logic serial_lock;
    } nvsc_image_t;
endpackage

// ===== verilog/nvsc_serial_mem.sv
// eight-byte serial number store with registered read data
`timescale 1ns/100ps
module nvsc_serial_mem
#(
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [2:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [DEPTH];

    // storage; reset leaves factory zeros
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= 8'h00;
            rdata <= 8'h00;
        end
        else if (ce)
        begin
            if (we)
                mem_reg[waddr] <= wdata;
            rdata <= mem_reg[raddr];
        end
    end
endmodule // nvsc_serial_mem

// ===== verilog/nvsc_top.sv
// i2c nv save/restore control: protection, lock, commands, busy pin
//
// Contract
// [RULE_01] protect field selects none, quarter, half, all
// [RULE_02] lock bit set once, then serial frozen
// [RULE_03] lock survives power only after a save
// [RULE_04] command register at aa is write only
// [RULE_05] 3c starts unconditional software save
// [RULE_06] 60 restores, nonvolatile cells untouched
// [RULE_07] 59/19 set autosave, settle blocks access
// [RULE_08] factory autosave on, cells zero
// [RULE_09] sleep: settle, busy low, save, doze
// [RULE_10] sleep save only if sram dirty
// [RULE_11] master sends start, target, aa, b9, stop
// [RULE_12] either target address wakes after exit time
// [RULE_13] nack every access during entry and exit
// [RULE_14] master polls addressing until acknowledged
// [RULE_15] write inhibit pin refuses all writes
// [RULE_16] power fail with autosave: block, dirty save
// [RULE_17] restore always at power-up
// [RULE_18] external busy low starts conditional save
// [RULE_19] busy pin low during every save
// [RULE_20] drive busy high briefly after save; after a power-fail save the code goes to NS_PF without it
// [RULE_21] hold access blocked after busy rises
// [RULE_22] external request one clock after last bit
// [RULE_23] protect bits in memory control at 00
// [RULE_24] protected write nacks, counter stays
// [RULE_25] durations are parameterised cycle counts
`timescale 1ns/100ps
module nvsc_top
#(
    parameter int SAVE_CYCLES = nvsc_pkg::SAVE_CYC, // [RULE_25]
    parameter int RESTORE_CYCLES = nvsc_pkg::RESTORE_CYC,
    parameter int SETTLE_CYCLES = nvsc_pkg::SETTLE_CYC,
    parameter int DOZE_IN_CYCLES = nvsc_pkg::DOZE_IN_CYC,
    parameter int DOZE_OUT_CYCLES = nvsc_pkg::DOZE_OUT_CYC,
    parameter int REQ_DLY_CYCLES = nvsc_pkg::REQ_DLY_CYC,
    parameter int HIGH_DRV_CYCLES = nvsc_pkg::HIGH_DRV_CYC,
    parameter int HOLD_CYCLES = nvsc_pkg::HOLD_CYC
)
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic WRITE_INHIBIT,
    input wire logic POWER_FAIL,
    input wire logic HW_SAVE_BUSY_IN,
    output logic HW_SAVE_BUSY_OUT,
    output logic HW_SAVE_BUSY_OE,
    input wire logic SRAM_WRITTEN,
    input wire logic [16:0] MEM_ADDR,
    output logic MEM_BLOCKED,
    output logic MEM_WRITE_OK,
    output logic NV_SAVE,
    output logic NV_RESTORE,
    output logic DOZE,
    output logic [7:0] MEM_CTRL,
    output logic [7:0] RD_DATA
);
    // ************************************************************
    // pin synchronisers and scl/sda edge finding
    // ************************************************************
    logic [1:0] scl_sync_reg, sda_sync_reg, busy_sync_reg;
    logic [1:0] pf_sync_reg, wi_sync_reg;
    logic scl_d_reg, sda_d_reg;
    // two flops per pin; scl and sda add a third for edge finding
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            busy_sync_reg <= 2'h3;
            pf_sync_reg <= 2'h0;
            wi_sync_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else if (CE)
        begin
            scl_sync_reg <= {scl_sync_reg[0], SCL};
            sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
            busy_sync_reg <= {busy_sync_reg[0], HW_SAVE_BUSY_IN};
            pf_sync_reg <= {pf_sync_reg[0], POWER_FAIL};
            wi_sync_reg <= {wi_sync_reg[0], WRITE_INHIBIT};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_ev = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
    wire stop_ev = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
    wire inhibit = wi_sync_reg[1]; // [RULE_15]
    wire busy_low_ext = ~busy_sync_reg[1];

    // ************************************************************
    // i2c byte receiver for the control-register target
    // ************************************************************
    typedef enum {BS_IDLE, BS_ADDR, BS_OFS, BS_DATA, BS_RDATA, BS_IGN}
        nvsc_bus_t;
    nvsc_bus_t bus_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg, ofs_reg;
    logic ack_reg, acking_reg, reg_tgt_reg, nack_next_reg;
    logic wr_pulse_reg, addr_hit_reg;
    nvsc_pkg::nvsc_wr_t wr_reg;
    logic accessible;

    // decode of a completed address byte
    wire [7:0] rx_byte = {sh_reg[6:0], sda_s};
    wire hit_reg_tgt = rx_byte[7:4] == nvsc_pkg::REG_TARGET_NIB;
    wire hit_mem_tgt = rx_byte[7:4] == nvsc_pkg::MEM_TARGET_NIB;
    wire byte_done = scl_rise && bit_reg == 4'h7;

    // receiver: shifts on rising scl, acks on the ninth clock
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            bus_reg <= BS_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            ofs_reg <= 8'h00;
            ack_reg <= 1'b0;
            acking_reg <= 1'b0;
            reg_tgt_reg <= 1'b0;
            wr_pulse_reg <= 1'b0;
            addr_hit_reg <= 1'b0;
            wr_reg <= '0;
        end
        else if (CE)
        begin
            wr_pulse_reg <= 1'b0;
            addr_hit_reg <= 1'b0;
            if (start_ev)
            begin
                bus_reg <= BS_ADDR;
                bit_reg <= 4'h0;
                acking_reg <= 1'b0;
            end
            else if (stop_ev)
            begin
                bus_reg <= BS_IDLE;
                acking_reg <= 1'b0;
            end
            else if (scl_fall && bit_reg == 4'h8)
            begin
                acking_reg <= ack_reg; // drive ack for the ninth clock
                bit_reg <= 4'h9;
            end
            else if (scl_fall && bit_reg == 4'h9)
            begin
                acking_reg <= 1'b0;
                bit_reg <= 4'h0;
                if (!ack_reg)
                    bus_reg <= BS_IGN; // after nack ignore to stop/start
            end
            else if (scl_rise && bit_reg < 4'h8)
            begin
                sh_reg <= rx_byte;
                bit_reg <= bit_reg + 4'h1;
                if (byte_done)
                begin
                    case (bus_reg)
                        BS_ADDR:
                        begin
                            addr_hit_reg <= hit_reg_tgt | hit_mem_tgt;
                            reg_tgt_reg <= hit_reg_tgt;
                            // [RULE_13] [RULE_14] nack while not ready
                            ack_reg <= hit_reg_tgt & accessible;
                            bus_reg <= rx_byte[0] ? BS_RDATA : BS_OFS;
                        end
                        BS_OFS:
                        begin
                            ofs_reg <= rx_byte;
                            ack_reg <= 1'b1;
                            bus_reg <= BS_DATA;
                        end
                        BS_DATA:
                        begin
                            // [RULE_15] [RULE_24] refused write nacks
                            ack_reg <= ~nack_next_reg;
                            wr_pulse_reg <= ~nack_next_reg;
                            wr_reg <= '{ofs: ofs_reg, data: rx_byte};
                            if (!nack_next_reg)
                                ofs_reg <= ofs_reg + 8'h01;
                        end
                        default:
                            ack_reg <= 1'b0;
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // control registers: protect, lock, serial, command
    // ************************************************************
    logic [1:0] protect_level_field_reg;
    logic serial_lock_bit_reg, autosave_en_reg;
    nvsc_pkg::nvsc_image_t image_reg;
    wire is_ctrl = ofs_reg == nvsc_pkg::MEM_CTRL_OFS;
    wire is_cmd = ofs_reg == nvsc_pkg::NV_COMMAND_ENTRY_OFS;
    wire is_serial = ofs_reg >= nvsc_pkg::SERIAL_FIRST_OFS &&
        ofs_reg <= nvsc_pkg::SERIAL_LAST_OFS;
    // unwritable: inhibit pin, locked serial, other offsets
    always_comb
    begin
        nack_next_reg = inhibit; // [RULE_15]
        if (is_serial && serial_lock_bit_reg)
            nack_next_reg = 1'b1; // [RULE_02]
        if (!(is_ctrl || is_cmd || is_serial))
            nack_next_reg = 1'b1;
        if (!reg_tgt_reg)
            nack_next_reg = 1'b1; // memory array is handled elsewhere
    end
    wire wr_ctrl = wr_pulse_reg && wr_reg.ofs == nvsc_pkg::MEM_CTRL_OFS;
    wire wr_cmd = // [RULE_04]
        wr_pulse_reg && wr_reg.ofs == nvsc_pkg::NV_COMMAND_ENTRY_OFS;
    wire wr_serial = wr_pulse_reg && !wr_ctrl && !wr_cmd;

    // command decode into actions
    wire c_save = wr_cmd && wr_reg.data == nvsc_pkg::CMD_SAVE; // [RULE_05]
    wire c_rest = wr_cmd && wr_reg.data == nvsc_pkg::CMD_RESTORE; // [RULE_06]
    wire c_on = wr_cmd && wr_reg.data == nvsc_pkg::AUTOSAVE_ON_CMD;
    wire c_off = wr_cmd && wr_reg.data == nvsc_pkg::AUTOSAVE_OFF_CMD;
    wire c_sleep = wr_cmd && wr_reg.data == nvsc_pkg::CMD_SLEEP; // [RULE_09]

    logic dirty_reg, save_done;
    // settings; lock is sticky-set and cleared only by reset or a restore from an unlocked image
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            protect_level_field_reg <= 2'h0;
            serial_lock_bit_reg <= 1'b0;
            autosave_en_reg <= 1'b1; // [RULE_08]
            image_reg <= '{autosave_en: 1'b1, serial_lock: 1'b0};
        end
        else if (CE)
        begin
            if (wr_ctrl)
            begin
                // [RULE_23]
                protect_level_field_reg <=
                    wr_reg.data[nvsc_pkg::PROTECT_LSB +: 2];
                if (wr_reg.data[nvsc_pkg::LOCK_BIT])
                    serial_lock_bit_reg <= 1'b1; // [RULE_02]
            end
            if (c_on)
                autosave_en_reg <= 1'b1; // [RULE_07]
            else if (c_off)
                autosave_en_reg <= 1'b0; // [RULE_07]
            if (save_done)
                image_reg <= '{autosave_en: autosave_en_reg,
                    serial_lock: serial_lock_bit_reg}; // [RULE_03]
            if (NV_RESTORE)
            begin
                // the restore pulls settings back from the image
                serial_lock_bit_reg <= image_reg.serial_lock; // [RULE_03]
                autosave_en_reg <= image_reg.autosave_en;
            end
        end
    end
    assign MEM_CTRL = {1'b0, serial_lock_bit_reg, 2'b00,
        protect_level_field_reg, 2'b00};

    // serial number memory
    logic [7:0] serial_rd;
    nvsc_serial_mem #(.DEPTH(8)) u_serial (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .we(wr_serial),
        .waddr(3'(wr_reg.ofs - 8'h01)),
        .wdata(wr_reg.data),
        .raddr(3'(ofs_reg - 8'h01)),
        .rdata(serial_rd)
    );

    // ************************************************************
    // array protection lookup
    // ************************************************************
    function automatic logic prot_hit(input logic [1:0] lvl,
        input logic [16:0] a);
        case (lvl)
            2'h1: prot_hit = a >= nvsc_pkg::QUARTER_BASE; // [RULE_01]
            2'h2: prot_hit = a >= nvsc_pkg::HALF_BASE; // [RULE_01]
            2'h3: prot_hit = 1'b1; // [RULE_01]
            default: prot_hit = 1'b0;
        endcase
    endfunction
    // [RULE_15] [RULE_24] array writes refused while protected
    assign MEM_WRITE_OK = ~prot_hit(protect_level_field_reg, MEM_ADDR) &
        ~inhibit & ~MEM_BLOCKED;

    // ************************************************************
    // nonvolatile sequencer
    // ************************************************************
    typedef enum {NS_BOOT, NS_READY, NS_SETTLE, NS_REQDLY, NS_SAVE,
        NS_HIGH, NS_HOLD, NS_RESTORE, NS_DOZE_IN, NS_DOZE, NS_DOZE_OUT,
        NS_PF} nvsc_seq_t;
    nvsc_seq_t seq_reg;
    logic [31:0] cnt_reg;
    logic sleep_pend_reg, pf_pend_reg;

    // dirty: set wins over clear when a write meets a save/restore
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            dirty_reg <= 1'b0;
        else if (CE)
        begin
            if (SRAM_WRITTEN)
                dirty_reg <= 1'b1;
            else if (save_done || NV_RESTORE)
                dirty_reg <= 1'b0;
        end
    end
    wire cnt_zero = cnt_reg == 32'd0;
    assign save_done = seq_reg == NS_SAVE && cnt_zero;
    wire pf_trip = pf_sync_reg[1] & autosave_en_reg; // [RULE_16]

    // sequencer; counts down cnt_reg in each timed state
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            seq_reg <= NS_BOOT;
            cnt_reg <= 32'(RESTORE_CYCLES); // [RULE_17]
            sleep_pend_reg <= 1'b0;
            pf_pend_reg <= 1'b0;
        end
        else if (CE)
        begin
            if (!cnt_zero)
                cnt_reg <= cnt_reg - 32'd1;
            case (seq_reg)
                NS_BOOT, NS_RESTORE:
                    if (cnt_zero)
                        seq_reg <= NS_READY; // [RULE_06] [RULE_17]
                NS_READY:
                    if (pf_trip)
                    begin
                        pf_pend_reg <= 1'b1;
                        seq_reg <= dirty_reg ? NS_SAVE : NS_PF; // [RULE_16]
                        cnt_reg <= 32'(SAVE_CYCLES);
                    end
                    else if (c_save)
                    begin
                        seq_reg <= NS_SAVE; // [RULE_05]
                        cnt_reg <= 32'(SAVE_CYCLES);
                    end
                    else if (c_rest)
                    begin
                        seq_reg <= NS_RESTORE;
                        cnt_reg <= 32'(RESTORE_CYCLES);
                    end
                    else if (c_on || c_off || c_sleep)
                    begin
                        sleep_pend_reg <= c_sleep;
                        seq_reg <= NS_SETTLE; // [RULE_07] [RULE_09]
                        cnt_reg <= 32'(SETTLE_CYCLES);
                    end
                    else if (busy_low_ext)
                    begin
                        seq_reg <= NS_REQDLY; // [RULE_18]
                        cnt_reg <= 32'(REQ_DLY_CYCLES);
                    end
                NS_SETTLE:
                    if (cnt_zero && sleep_pend_reg)
                    begin
                        // [RULE_10] sleep save only when dirty
                        seq_reg <= dirty_reg ? NS_SAVE : NS_DOZE_IN;
                        cnt_reg <= dirty_reg ? 32'(SAVE_CYCLES)
                            : 32'(DOZE_IN_CYCLES);
                    end
                    else if (cnt_zero)
                        seq_reg <= NS_READY;
                NS_REQDLY:
                    if (cnt_zero)
                    begin
                        // [RULE_18] conditional on dirty
                        seq_reg <= dirty_reg ? NS_SAVE : NS_HOLD;
                        cnt_reg <= dirty_reg ? 32'(SAVE_CYCLES)
                            : 32'(HOLD_CYCLES);
                    end
                NS_SAVE:
                    if (save_done)
                    begin
                        seq_reg <= pf_pend_reg ? NS_PF : NS_HIGH;
                        cnt_reg <= 32'(HIGH_DRV_CYCLES);
                    end
                NS_HIGH:
                    if (cnt_zero)
                    begin
                        seq_reg <= NS_HOLD; // [RULE_20]
                        cnt_reg <= 32'(HOLD_CYCLES);
                    end
                NS_HOLD:
                    if (cnt_zero && busy_sync_reg[1])
                    begin
                        // [RULE_21] then sleep if requested
                        seq_reg <= sleep_pend_reg ? NS_DOZE_IN : NS_READY;
                        cnt_reg <= 32'(DOZE_IN_CYCLES);
                    end
                NS_DOZE_IN:
                    if (cnt_zero)
                    begin
                        seq_reg <= NS_DOZE;
                        sleep_pend_reg <= 1'b0;
                    end
                NS_DOZE:
                    if (addr_hit_reg)
                    begin
                        seq_reg <= NS_DOZE_OUT; // [RULE_12]
                        cnt_reg <= 32'(DOZE_OUT_CYCLES);
                    end
                NS_DOZE_OUT:
                    if (cnt_zero)
                        seq_reg <= NS_READY; // [RULE_12]
                NS_PF:
                    seq_reg <= NS_PF; // held until power returns (reset)
                default:
                    seq_reg <= NS_READY;
            endcase
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign accessible = seq_reg == NS_READY; // [RULE_13]
    assign MEM_BLOCKED = !accessible || busy_low_ext; // [RULE_16] [RULE_18]
    assign NV_SAVE = seq_reg == NS_SAVE;
    assign NV_RESTORE = (seq_reg == NS_BOOT || seq_reg == NS_RESTORE)
        && cnt_zero;
    assign DOZE = seq_reg == NS_DOZE;
    // busy pin: low during save and the last settle cycle of sleep entry, high drive after a save unless power failed
    wire busy_drive_low = seq_reg == NS_SAVE ||
        (seq_reg == NS_SETTLE && sleep_pend_reg && cnt_zero); // [RULE_19]
    assign HW_SAVE_BUSY_OUT = seq_reg == NS_HIGH; // [RULE_20]
    assign HW_SAVE_BUSY_OE = busy_drive_low || seq_reg == NS_HIGH;
    // sda: ack low on the ninth clock, read data on the regs
    assign SDA_OE = acking_reg;
    assign SDA_OUT = 1'b0;
    assign RD_DATA = (ofs_reg == nvsc_pkg::MEM_CTRL_OFS) ? MEM_CTRL
        : serial_rd;
endmodule // nvsc_top

// ===== tb/nvsc_asserts.sv
// port checker for the nv save/restore control block
`timescale 1ns/100ps
module nvsc_asserts (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WRITE_INHIBIT,
    input wire logic HW_SAVE_BUSY_OUT,
    input wire logic HW_SAVE_BUSY_OE,
    input wire logic MEM_BLOCKED,
    input wire logic MEM_WRITE_OK,
    input wire logic NV_SAVE,
    input wire logic NV_RESTORE,
    input wire logic DOZE,
    input wire logic [7:0] MEM_CTRL
);
    // single clock domain
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    chk_save_busy_low:
        assert property (NV_SAVE |-> HW_SAVE_BUSY_OE && !HW_SAVE_BUSY_OUT)
        else $error("busy pin not low in save");
    chk_busy_high_drive:
        assert property ($fell(NV_SAVE) |->
            ##[0:3] (HW_SAVE_BUSY_OE && HW_SAVE_BUSY_OUT))
        else $error("busy pin not driven high after save");
    chk_post_save_hold:
        assert property ($fell(NV_SAVE) |-> MEM_BLOCKED[*2])
        else $error("access freed at save end");
    chk_full_protect:
        assert property (MEM_CTRL[3:2] == 2'b11 |-> !MEM_WRITE_OK)
        else $error("write allowed with whole array protected");
    // inhibit crosses a synchroniser first
    chk_inhibit_write:
        assert property (WRITE_INHIBIT[*4] |-> !MEM_WRITE_OK)
        else $error("write allowed under inhibit");
    chk_lock_sticky:
        assert property (MEM_CTRL[6] && !NV_RESTORE |=> MEM_CTRL[6])
        else $error("lock bit cleared");
    chk_doze_blocked:
        assert property (DOZE |-> MEM_BLOCKED)
        else $error("access open while asleep");
    chk_boot_restore:
        assert property ($rose(RSTN) |-> MEM_BLOCKED)
        else $error("no restore after reset");
    cov_save: cover property (NV_SAVE);
    cov_doze: cover property (DOZE);
    cov_restore: cover property (NV_RESTORE);
endmodule // nvsc_asserts

// ===== tb/nvsc_master.sv
// behavioural i2c bus master, 125 ns bit time, scl idles high
`timescale 1ns/100ps
module nvsc_master (
    input wire logic sda_lvl,
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1
);
    // one bit: data moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        #31.25 scl = 1'b1;
        #31.25 r = sda_lvl;
        #31.25 scl = 0;
        #31.25;
    endtask
    // start, n bytes of v, stop
    task automatic frame(input logic [23:0] v, input int n,
                         output logic [2:0] acks);
        logic r;
        acks = 3'b000;
        sda_drv = 1'b0;
        #31.25 scl = 1'b0;
        for (int i = 23; i >= 24 - 8 * n; i--)
        begin
            bit_io(v[i], r);
            if (i % 8 == 0)
            begin
                bit_io(1'b1, r);
                acks[i / 8] = !r;
            end
        end
        sda_drv = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda_drv = 1'b1;
        #31.25;
    endtask
endmodule // nvsc_master

// ===== tb/test_nvsc_top.sv
// self-checking bench for the nv save/restore control block
`timescale 1ns/100ps
`define CHK(g, e, m) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("[FAIL] %0t %s", $time, m); \
        end \
    end
module test_nvsc_top;
    logic clk = 0, rstn = 0, inhibit = 0, pfail = 0, ext_n = 1, wr = 0;
    logic [16:0] addr = 17'h0;
    logic scl, sda_drv, sda_oe, sda_out, b_out, b_oe, blocked, wr_ok;
    logic save, restore, doze, saw_save = 0;
    logic [7:0] ctrl;
    logic [2:0] a;
    logic [7:0] cmds [4] = '{8'h3c, 8'h60, 8'h19, 8'h59};
    int n_errors = 0, samples_checked = 0, seed = 80;
    // open-drain wires with pull-ups
    wire sda_lvl = (sda_oe ? sda_out : 1'b1) & sda_drv;
    wire busy_lvl = (b_oe ? b_out : 1'b1) & ext_n;
    nvsc_master u_m (.sda_lvl(sda_lvl), .scl(scl), .sda_drv(sda_drv));
    nvsc_top u_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .SCL(scl),
        .SDA_IN(sda_lvl), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .WRITE_INHIBIT(inhibit), .POWER_FAIL(pfail),
        .HW_SAVE_BUSY_IN(busy_lvl), .HW_SAVE_BUSY_OUT(b_out),
        .HW_SAVE_BUSY_OE(b_oe), .SRAM_WRITTEN(wr), .MEM_ADDR(addr),
        .MEM_BLOCKED(blocked), .MEM_WRITE_OK(wr_ok), .NV_SAVE(save),
        .NV_RESTORE(restore), .DOZE(doze), .MEM_CTRL(ctrl), .RD_DATA());
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (save === 1'b1) saw_save <= 1'b1;
    // writable unless the protect level covers this address
    function automatic logic exp_ok(input logic [1:0] p, input logic [16:0] m);
        return p == 0 || (p == 1 && m < nvsc_pkg::QUARTER_BASE) ||
            (p == 2 && m < nvsc_pkg::HALF_BASE);
    endfunction
    // bounded wait
    task automatic till(ref logic s, input logic v);
        repeat (3000) if (s !== v) @(posedge clk);
    endtask
    task automatic dirty;
        @(posedge clk) wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        saw_save = 1'b0;
    endtask
    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang counts as a mismatch; tests need about 85 us
    initial
    begin
        #900us n_errors++;
        final_report;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        till(blocked, 1'b0);
        `CHK(ctrl, 8'h00, "reset image")
        for (int p = 3; p >= 0; p--)
        begin
            u_m.frame({16'h3000, 4'h0, p[1:0], 2'b00}, 3, a);
            `CHK(a, 3'b111, "protect write nacked")
            repeat (16)
            begin
                @(posedge clk) addr <= 17'($random(seed));
                @(posedge clk) `CHK(wr_ok, exp_ok(p[1:0], addr), "range")
            end
        end
        foreach (cmds[i])
        begin
            saw_save = 1'b0;
            u_m.frame({16'h30aa, cmds[i]}, 3, a);
            `CHK(a, 3'b111, "command nacked")
            till(blocked, 1'b0);
            `CHK(saw_save, cmds[i] == 8'h3c, "save launch")
        end
        @(posedge clk) inhibit <= 1'b1;
        u_m.frame(24'h30000c, 3, a);
        `CHK({a[0], ctrl}, 9'h000, "write under inhibit")
        @(posedge clk) inhibit <= 1'b0;
        u_m.frame(24'h300040, 3, a);
        u_m.frame(24'h300000, 3, a);
        u_m.frame(24'h30015a, 3, a);
        `CHK({ctrl[6], a[0]}, 2'b10, "lock")
        dirty;
        u_m.frame(24'h30aab9, 3, a);
        till(doze, 1'b1);
        `CHK({saw_save, doze}, 2'b11, "sleep entry")
        u_m.frame(24'ha00000, 1, a);
        `CHK(a[2], 1'b0, "acked while waking")
        repeat (8) if (a[2] !== 1'b1) u_m.frame(24'h300000, 1, a);
        `CHK(a[2], 1'b1, "no wake")
        dirty;
        ext_n <= 1'b0;
        repeat (30) @(posedge clk);
        ext_n <= 1'b1;
        till(save, 1'b1);
        `CHK(save, 1'b1, "hardware request ignored")
        till(blocked, 1'b0);
        @(posedge clk) pfail <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(blocked, 1'b1, "power fail not blocking")
        final_report;
    end
endmodule // test_nvsc_top
bind nvsc_top nvsc_asserts u_chk (.CLK(CLK), .RSTN(RSTN),
    .WRITE_INHIBIT(WRITE_INHIBIT), .HW_SAVE_BUSY_OUT(HW_SAVE_BUSY_OUT),
    .HW_SAVE_BUSY_OE(HW_SAVE_BUSY_OE), .MEM_BLOCKED(MEM_BLOCKED),
    .MEM_WRITE_OK(MEM_WRITE_OK), .NV_SAVE(NV_SAVE), .NV_RESTORE(NV_RESTORE),
    .DOZE(DOZE), .MEM_CTRL(MEM_CTRL));
